/* hplr_line_swap.sv */
`timescale 1ns/10ps
`default_nettype none
// One port's plus/minus exchange, registered so the mapping switches cleanly
module hplr_line_swap (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic swap_i,
  input  wire logic core_plus_i,
  input  wire logic core_minus_i,
  output logic      usb_plus_line_o,
  output logic      usb_minus_line_o
);
  logic plus_nxt;
  logic minus_nxt;

  // Cross the pair when swapped, straight through otherwise
  assign plus_nxt  = swap_i ? core_minus_i : core_plus_i;
  assign minus_nxt = swap_i ? core_plus_i  : core_minus_i;

  // Outputs come from flops; a swap change lands on the next edge
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      usb_plus_line_o  <= 1'b0;
      usb_minus_line_o <= 1'b0;
    end else begin
      usb_plus_line_o  <= plus_nxt;
      usb_minus_line_o <= minus_nxt;
    end
  end
endmodule : hplr_line_swap
`default_nettype wire

/* hplr_loader_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Stands in for the SMBus host or EEPROM loader; one byte per strobe
module hplr_loader_model (
  input  wire logic       clk_sys_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  // Quiet bus at time zero
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'hFF;
    reg_wdata_o = 8'hFF;
  end
  // A released bus shows inverted bytes, so a stale value never looks live
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask : wr
  // Read data is taken only in the cycle that carries the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    ok = 1'b0;
    d  = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid_i === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata_i;
      end else @(negedge clk_sys_i);
    end
  endtask : rd
endmodule : hplr_loader_model
`default_nettype wire

/* hplr_pkg.sv */
package hplr_pkg;
  // Register offsets within the configuration space
  localparam logic [7:0] LINE_SWAP_CONTROL_OFS   = 8'h0B;
  localparam logic [7:0] UNIQUE_ID_FIRST_OFS     = 8'h10;
  localparam logic [7:0] UNIQUE_ID_LAST_OFS      = 8'h1F;
  localparam logic [7:0] LANGUAGE_CODE_LOW_OFS   = 8'h20;
  // Field positions of the line swap control register
  localparam int         UPSTREAM_SWAP_BIT       = 0;
  localparam int         PORT_COUNT              = 5;
  localparam int         OVERRIDE_ENABLE_BIT     = 7;
  // Reset values
  localparam logic [7:0] LINE_SWAP_CONTROL_RST   = 8'h00;
  localparam logic [7:0] LANGUAGE_CODE_LOW_RST   = 8'h09;
  // Fixed language code high byte, held outside this block
  localparam logic [7:0] LANGUAGE_CODE_HIGH_RST  = 8'h04;
  // Identifier value; arbitrary, replaced per part in production
  localparam logic [127:0] UNIQUE_ID_DEFAULT     = 128'h0123456789AB_4CDE_8F01_23456789ABCD;
endpackage : hplr_pkg

/* hplr_regs.sv */
// Operation
// - Clear swap bit keeps a port's plus and minus lines as wired.
// - Set swap bit exchanges the port's plus and minus lines.
// - Bit 0 is upstream; bits 1 to 4 are downstream ports 1 to 4.
// - Swap bits ignore writes unless the same write sets the override enable to 1.
// - With override enable 0, swap bits read the one-time-programmed values.
// - Sixteen read-only identifier bytes at 10h-1Fh feed the Container ID.
// - The device supplies the identifier, formatted as an RFC 4122 UUID.
// - Language low byte register is the low byte of index 0 language code.
// - Language low byte resets to 09h, giving code 0409h.
// - Exactly one language code is reported, from the low/high pair.
// - Language low byte writable only while string override enable is 1.
// - Override enable is bit 7; when set, swap bits come from loader writes.
// - One write may set the enable and the swap bits together.
`timescale 1ns/10ps
`default_nettype none
module hplr_regs
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         rstn_i,
  // Register access from the loader or SMBus engine
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  input  wire logic [7:0]                   reg_addr_i,
  input  wire logic [7:0]                   reg_wdata_i,
  output logic      [7:0]                   reg_rdata_o,
  output logic                              reg_rvalid_o,
  // Configuration straps and one-time-programmed values
  input  wire logic                         string_override_enable_i,
  input  wire logic [hplr_pkg::PORT_COUNT-1:0] otp_line_swap_i,
  // Core-side and USB-side line values per port, index as the swap bits
  input  wire logic [hplr_pkg::PORT_COUNT-1:0] core_plus_i,
  input  wire logic [hplr_pkg::PORT_COUNT-1:0] core_minus_i,
  output logic      [hplr_pkg::PORT_COUNT-1:0] usb_plus_line_o,
  output logic      [hplr_pkg::PORT_COUNT-1:0] usb_minus_line_o,
  // Descriptor feeds
  output logic      [127:0]                 container_id_o,
  output logic      [15:0]                  language_code_o
);
  import hplr_pkg::*;

  logic                  line_swap_override_enable_r;
  logic [PORT_COUNT-1:0] line_swap_custom_r;
  logic [7:0]            language_code_low_byte_r;
  logic [PORT_COUNT-1:0] line_swap_eff;
  logic                  hit_swap;
  logic                  hit_id;
  logic                  hit_lang;
  logic [3:0]            id_index;
  logic [7:0]            id_byte;
  logic [7:0]            rdata_nxt;
  logic                  swap_wr;
  logic                  lang_wr;
  logic                  new_enable;
  logic                  upstream_line_swap;
  logic                  downstream1_line_swap;
  logic                  downstream2_line_swap;
  logic                  downstream3_line_swap;
  logic                  downstream4_line_swap;

  // Address decode
  assign hit_swap = (reg_addr_i == LINE_SWAP_CONTROL_OFS);
  assign hit_id   = (reg_addr_i >= UNIQUE_ID_FIRST_OFS) && (reg_addr_i <= UNIQUE_ID_LAST_OFS);
  assign hit_lang = (reg_addr_i == LANGUAGE_CODE_LOW_OFS);
  assign id_index = reg_addr_i[3:0];

  // Write qualifiers; the enable bit in the same write opens the swap bits
  assign swap_wr    = reg_wr_i && hit_swap;
  assign new_enable = reg_wdata_i[OVERRIDE_ENABLE_BIT];
  assign lang_wr    = reg_wr_i && hit_lang && string_override_enable_i;

  // Effective mapping: OTP while locked, custom value when overridden
  assign line_swap_eff = line_swap_override_enable_r ? line_swap_custom_r : otp_line_swap_i;

  // Named per-port views of the swap field
  assign upstream_line_swap    = line_swap_eff[UPSTREAM_SWAP_BIT];
  assign downstream1_line_swap = line_swap_eff[1];
  assign downstream2_line_swap = line_swap_eff[2];
  assign downstream3_line_swap = line_swap_eff[3];
  assign downstream4_line_swap = line_swap_eff[4];

  // Identifier byte N is taken from the top so byte 0 is most significant
  assign id_byte = container_id_o[127 - 8*id_index -: 8];

  // Read mux; unmapped addresses and reserved bits read zero
  assign rdata_nxt = hit_swap ? {line_swap_override_enable_r, 2'b00, line_swap_eff} :
                     hit_id   ? id_byte :
                     hit_lang ? language_code_low_byte_r : 8'h00;

  // Swap control register
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      line_swap_override_enable_r <= LINE_SWAP_CONTROL_RST[OVERRIDE_ENABLE_BIT];
      line_swap_custom_r          <= LINE_SWAP_CONTROL_RST[PORT_COUNT-1:0];
    end else if (swap_wr) begin
      line_swap_override_enable_r <= new_enable;
      if (new_enable) begin
        line_swap_custom_r <= reg_wdata_i[PORT_COUNT-1:0];
      end
    end
  end

  // Language low byte register
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      language_code_low_byte_r <= LANGUAGE_CODE_LOW_RST;
    end else if (lang_wr) begin
      language_code_low_byte_r <= reg_wdata_i;
    end
  end

  // Read data and descriptor outputs, all registered
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      reg_rdata_o     <= 8'h00;
      reg_rvalid_o    <= 1'b0;
      container_id_o  <= UNIQUE_ID_DEFAULT;
      language_code_o <= {LANGUAGE_CODE_HIGH_RST, LANGUAGE_CODE_LOW_RST};
    end else begin
      reg_rdata_o     <= reg_rd_i ? rdata_nxt : 8'h00;
      reg_rvalid_o    <= reg_rd_i;
      container_id_o  <= UNIQUE_ID_DEFAULT;
      language_code_o <= {LANGUAGE_CODE_HIGH_RST, language_code_low_byte_r};
    end
  end

  // One swapper per port; the registered stage settles the map ahead of use
  genvar p;
  generate
    for (p = 0; p < PORT_COUNT; p++) begin : g_port
      hplr_line_swap u_swap (
        .clk_sys_i       (clk_sys_i),
        .rstn_i          (rstn_i),
        .swap_i          (line_swap_eff[p]),
        .core_plus_i     (core_plus_i[p]),
        .core_minus_i    (core_minus_i[p]),
        .usb_plus_line_o (usb_plus_line_o[p]),
        .usb_minus_line_o(usb_minus_line_o[p])
      );
    end
  endgenerate

  // Checks
  swap_locked_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    swap_wr && !new_enable |=> $stable(line_swap_custom_r))
    else $error("swap bits changed without enable");
  swap_same_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    swap_wr && new_enable |=> line_swap_custom_r == $past(reg_wdata_i[PORT_COUNT-1:0]))
    else $error("swap bits not taken with enable");
  otp_view_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !line_swap_override_enable_r |-> line_swap_eff == otp_line_swap_i)
    else $error("locked swap bits do not show OTP");
  lang_locked_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_wr_i && hit_lang && !string_override_enable_i |=> $stable(language_code_low_byte_r))
    else $error("language byte written while locked");
  lang_report_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 language_code_o == {LANGUAGE_CODE_HIGH_RST, $past(language_code_low_byte_r)})
    else $error("language code not from low byte");
  straight_map_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !upstream_line_swap |=> usb_plus_line_o[0] == $past(core_plus_i[0]))
    else $error("unswapped upstream pair crossed");
  swapped_map_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    downstream4_line_swap |=> usb_plus_line_o[4] == $past(core_minus_i[4]))
    else $error("swapped port 4 pair not crossed");
  id_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_rd_i && reg_addr_i == UNIQUE_ID_FIRST_OFS |=> reg_rdata_o == UNIQUE_ID_DEFAULT[127:120])
    else $error("identifier byte 0 misread");
  lang_reset_a: assert property (@(posedge clk_sys_i)
    !rstn_i |=> language_code_low_byte_r == LANGUAGE_CODE_LOW_RST)
    else $error("language byte reset value wrong");
  swap_bits_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_rd_i && hit_swap |=> reg_rdata_o[6:5] == 2'b00 && reg_rdata_o[3] == $past(downstream3_line_swap))
    else $error("swap register layout wrong");
  swap_mid_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_rd_i && hit_swap |=> reg_rdata_o[2:1] == $past({downstream2_line_swap, downstream1_line_swap}))
    else $error("swap register middle bits wrong");
  // Read answers stand exactly one cycle, and the bus reads zero otherwise
  read_valid_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  read_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !reg_rd_i |=> !reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("read data not quiet");
  // A write with the enable clear relocks the ports to the OTP values
  swap_relock_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    swap_wr && !new_enable |=> !line_swap_override_enable_r)
    else $error("override enable not cleared");
  lang_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    lang_wr |=> language_code_low_byte_r == $past(reg_wdata_i))
    else $error("language byte write lost");
  id_last_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    reg_rd_i && reg_addr_i == UNIQUE_ID_LAST_OFS |=> reg_rdata_o == UNIQUE_ID_DEFAULT[7:0])
    else $error("identifier byte 15 misread");
  swap_minus_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    upstream_line_swap |=> usb_minus_line_o[0] == $past(core_plus_i[0]))
    else $error("swapped upstream minus not crossed");
endmodule : hplr_regs
`default_nettype wire

/* hub_polarity_uuid_langid_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module hub_polarity_uuid_langid_regs_tb;
  import hplr_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         rstn_i    = 1'b0;
  logic         sen       = 1'b0;
  logic [4:0]   otp       = 5'h15;
  logic [4:0]   cp        = 5'h0C;
  logic [4:0]   cm        = 5'h13;
  logic         reg_wr, reg_rd, rvalid;
  logic [7:0]   addr, wdata, rdata;
  logic [4:0]   up, um;
  logic [127:0] cid;
  logic [15:0]  lang;
  int           err_total       = 0;
  int           samples_checked = 0;
  // {write, string enable, address, write data, expected read}
  logic [25:0] rows [0:8] = '{26'h00B0015, 26'h20B0A15, 26'h20B8A8A, 26'h20B0A15, 26'h0200009,
                              26'h2205A09, 26'h3205A5A, 26'h31FAACD, 26'h1300000};
  always #25 clk_sys_i = ~clk_sys_i;
  hplr_regs u_hplr_regs (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .string_override_enable_i(sen), .otp_line_swap_i(otp), .core_plus_i(cp), .core_minus_i(cm),
    .usb_plus_line_o(up), .usb_minus_line_o(um), .container_id_o(cid), .language_code_o(lang));
  hplr_loader_model u_hplr_loader_model (.clk_sys_i(clk_sys_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // A read that never answers ends the run at once
  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_hplr_loader_model.rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_total++;
      close_out();
    end else begin
      check(d, exp);
    end
  endtask : read_chk
  // Lines are registered, so give the new mapping two edges to land
  task automatic lines_chk(input logic [4:0] s);
    repeat (2) @(negedge clk_sys_i);
    check(up, (cp & ~s) | (cm & s));
    check(um, (cm & ~s) | (cp & s));
  endtask : lines_chk
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    lines_chk(otp);
    check(lang, 16'h0409);
    check(cid, UNIQUE_ID_DEFAULT);
    for (int i = 0; i < 9; i++) begin
      sen = rows[i][24];
      if (rows[i][25]) u_hplr_loader_model.wr(rows[i][23:16], rows[i][15:8]);
      read_chk(rows[i][23:16], rows[i][7:0]);
    end
    for (int b = 0; b < 16; b++) read_chk(8'h10 + 8'(b), UNIQUE_ID_DEFAULT[127 - 8*b -: 8]);
    check(lang, 16'h045A);
    $display("register table done");
    u_hplr_loader_model.wr(8'h0B, 8'h83);
    lines_chk(5'h03);
    u_hplr_loader_model.wr(8'h0B, 8'h9C);
    lines_chk(5'h1C);
    u_hplr_loader_model.wr(8'h0B, 8'h81);
    u_hplr_loader_model.wr(8'h0B, 8'h02);
    read_chk(8'h0B, 8'h15);
    lines_chk(otp);
    $display("line mapping done");
    @(negedge clk_sys_i);
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    check(lang, 16'h0409);
    read_chk(8'h20, 8'h09);
    read_chk(8'h0B, 8'h15);
    $display("second reset done");
    close_out();
  end
endmodule : hub_polarity_uuid_langid_regs_tb
`default_nettype wire
